// ==== include/hwm_pkg.sv ====
// Purpose: constants shared by the hardware monitor event and power control block
// Assumes: 20 MHz mclk, byte-wide register port from the serial management front end
// Notes: offsets of limit and reading registers are local choices
package hwm_pkg;
  localparam logic [7:0] ADDR_RLR = 8'h40;
  localparam logic [7:0] ADDR_STAT1 = 8'h41;
  localparam logic [7:0] ADDR_STAT2 = 8'h42;
  localparam logic [7:0] ADDR_SFR = 8'h7c;
  localparam logic [7:0] ADDR_VOLT_GROUP_ENABLE = 8'h7e;
  localparam logic [7:0] ADDR_CONFIG_REGISTER = 8'h7f;
  localparam logic [7:0] ADDR_FAN_EN = 8'h80;
  localparam logic [7:0] ADDR_TEMP_EN = 8'h82;
  localparam logic [7:0] ADDR_READ_BASE = 8'h20;
  localparam logic [7:0] ADDR_LO_BASE = 8'h44;
  localparam logic [7:0] ADDR_HI_BASE = 8'h4c;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int NUM_FAN = 4;
  // conversion order: remote1, ambient, vcc, 12v, 5v, 2.5v, vccp, remote2
  localparam logic [2:0] CH_REMOTE1 = 3'h0;
  localparam logic [2:0] CH_AMBIENT = 3'h1;
  localparam logic [2:0] CH_REMOTE2 = 3'h7;
  localparam logic [7:0] TEMP_CH_MASK = 8'h83;
  localparam logic [7:0] VOLT_CH_MASK = 8'h7c;
  localparam int RLR_RUN = 0;
  localparam int RLR_LOCK = 1;
  localparam int RLR_READY = 2;
  localparam int SFR_LPSEL = 0;
  localparam int SFR_GLOBAL_EN = 2;
  localparam logic [7:0] SFR_SHUTDOWN_WMASK = 8'h07;
  localparam int CONFIG_REGISTER_SPEED3_ALERT = 0;
  localparam int CONFIG_REGISTER_DRIVE2_ALERT = 1;
  localparam int CONFIG_REGISTER_SOFT_INIT = 7;
  localparam int GROUP_EN = 0;
  localparam int ST2_FAULT_R1 = 6;
  localparam int ST2_FAULT_R2 = 7;
  localparam logic [7:0] SFR_RST = 8'h40;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] SENSOR_ERROR = 8'h80;
  localparam logic [7:0] DISABLED_READ = 8'h00;
  localparam int CLK_KHZ = 20000;
  localparam int IDLE_WAIT_MS = 1000;
  localparam int unsigned IDLE_CYCLES_DEF = IDLE_WAIT_MS * CLK_KHZ;
  localparam int IDLE_CNT_W = 25;
  typedef enum logic [1:0] {
    HWM_STOPPED = 2'b00,
    HWM_REQ = 2'b01,
    HWM_WAIT = 2'b10,
    HWM_PAUSE = 2'b11
  } hwm_state_t;
endpackage

// ==== rtl/hwm_irq_pwr.sv ====
// Purpose: monitoring sequencer, limit status, alert routing and low-power control
// Assumes: register port and converter handshake on mclk; diode and tach fault pins asynchronous
// Notes: alert pins are open-drain; *_oe high means the pin is pulled low
`timescale 1ns/10ps
module hwm_irq_pwr #(
  parameter int unsigned IDLE_CYCLES = hwm_pkg::IDLE_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic ara_req,
  output logic conv_start,
  output logic [2:0] conv_chan,
  input wire logic conv_done,
  input wire logic [7:0] conv_data,
  input wire logic [1:0] diode_fault_pin,
  input wire logic [1:0] diode_neg_gnd_pin,
  input wire logic [3:0] fan_fault_pin,
  output logic alert_n,
  output logic drive2_alert_oe,
  output logic speed3_alert_oe,
  output logic [2:0] zone_full_on,
  output logic osc_enable,
  output logic adc_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      pin_meta <= {fan_fault_pin, diode_neg_gnd_pin, diode_fault_pin};
      pin_sync <= pin_meta;
    end
  end
  logic [1:0] diode_fault;
  logic [1:0] diode_neg_gnd;
  logic [3:0] fan_fault;
  assign diode_fault = pin_sync[1:0];
  assign diode_neg_gnd = pin_sync[3:2];
  assign fan_fault = pin_sync[7:4];

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic run;
  logic lock;
  logic ready;
  logic [7:0] sfr;
  logic [7:0] config_register;
  logic [7:0] volt_group_enable;
  logic [7:0] fan_en;
  logic [7:0] temp_en;
  logic [7:0] lim_lo [hwm_pkg::NUM_CH];
  logic [7:0] lim_hi [hwm_pkg::NUM_CH];
  logic [7:0] reading [hwm_pkg::NUM_CH];
  logic shutdown;
  logic active;
  logic wr_any;
  logic soft_init;
  logic pass_done;

  assign active = run;
  assign shutdown = !run && sfr[hwm_pkg::SFR_LPSEL];
  // in shutdown only the sfr and config register take writes
  assign wr_any = reg_wr && (!shutdown || reg_addr == hwm_pkg::ADDR_SFR || reg_addr == hwm_pkg::ADDR_CONFIG_REGISTER);
  assign soft_init = wr_any && reg_addr == hwm_pkg::ADDR_CONFIG_REGISTER && reg_wdata[hwm_pkg::CONFIG_REGISTER_SOFT_INIT];

  always_ff @(posedge mclk)
  begin
    if (reset || soft_init)
    begin
      run <= 1'b0;
      lock <= 1'b0;
      sfr <= hwm_pkg::SFR_RST;
      config_register <= hwm_pkg::REG_RST;
      volt_group_enable <= hwm_pkg::REG_RST;
      fan_en <= hwm_pkg::REG_RST;
      temp_en <= hwm_pkg::REG_RST;
    end
    else if (wr_any)
    begin
      unique case (reg_addr)
        hwm_pkg::ADDR_RLR:
        begin
          if (!lock)
            run <= reg_wdata[hwm_pkg::RLR_RUN];
          lock <= lock | reg_wdata[hwm_pkg::RLR_LOCK];
        end
        hwm_pkg::ADDR_SFR:
        begin
          if (shutdown)
            sfr[2:1] <= reg_wdata[2:1];
          else
            sfr[7:1] <= reg_wdata[7:1];
          if (!lock)
            sfr[hwm_pkg::SFR_LPSEL] <= reg_wdata[hwm_pkg::SFR_LPSEL];
        end
        hwm_pkg::ADDR_CONFIG_REGISTER: config_register <= {1'b0, reg_wdata[6:0]};
        hwm_pkg::ADDR_VOLT_GROUP_ENABLE: volt_group_enable <= reg_wdata;
        hwm_pkg::ADDR_FAN_EN: fan_en <= reg_wdata;
        hwm_pkg::ADDR_TEMP_EN: temp_en <= reg_wdata;
        default:
        begin
        end
      endcase
    end
  end

  // limits reset with the rest; readings survive soft init
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < hwm_pkg::NUM_CH; i++)
    begin
      if (reset || soft_init)
      begin
        lim_lo[i] <= hwm_pkg::REG_RST;
        lim_hi[i] <= hwm_pkg::SENSOR_ERROR - 8'h01;
      end
      else if (wr_any && reg_addr == hwm_pkg::ADDR_LO_BASE + 8'(i))
        lim_lo[i] <= reg_wdata;
      else if (wr_any && reg_addr == hwm_pkg::ADDR_HI_BASE + 8'(i))
        lim_hi[i] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitoring sequencer
  hwm_pkg::hwm_state_t state;
  logic [hwm_pkg::IDLE_CNT_W-1:0] idle_cnt;
  localparam logic [hwm_pkg::IDLE_CNT_W-1:0] IDLE_LAST = hwm_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1);

  always_ff @(posedge mclk)
  begin
    if (reset || soft_init || !run)
    begin
      state <= hwm_pkg::HWM_STOPPED;
      conv_start <= 1'b0;
      conv_chan <= hwm_pkg::CH_REMOTE1;
      idle_cnt <= '0;
    end
    else
    begin
      conv_start <= 1'b0;
      unique case (state)
        hwm_pkg::HWM_STOPPED:
        begin
          conv_chan <= hwm_pkg::CH_REMOTE1;
          state <= hwm_pkg::HWM_REQ;
        end
        hwm_pkg::HWM_REQ:
        begin
          conv_start <= 1'b1;
          state <= hwm_pkg::HWM_WAIT;
        end
        hwm_pkg::HWM_WAIT:
          if (conv_done)
          begin
            conv_chan <= conv_chan + 3'h1;
            idle_cnt <= '0;
            state <= (conv_chan == hwm_pkg::CH_REMOTE2) ? hwm_pkg::HWM_PAUSE : hwm_pkg::HWM_REQ;
          end
        hwm_pkg::HWM_PAUSE:
          if (idle_cnt == IDLE_LAST)
            state <= hwm_pkg::HWM_REQ;
          else
            idle_cnt <= idle_cnt + 1'b1;
      endcase
    end
  end

  assign pass_done = state == hwm_pkg::HWM_WAIT && conv_done && conv_chan == hwm_pkg::CH_REMOTE2;

  always_ff @(posedge mclk)
  begin
    if (reset || soft_init)
      ready <= 1'b0;
    else if (pass_done)
      ready <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reading update and limit compare
  logic upd;
  logic is_temp;
  logic is_remote;
  logic rsel;
  logic diode_on;
  logic rfault;
  logic [7:0] new_val;
  logic err_new;
  logic ind_en;
  logic [7:0] set1;
  logic [7:0] cur_err;

  assign upd = state == hwm_pkg::HWM_WAIT && conv_done && run;
  assign is_temp = hwm_pkg::TEMP_CH_MASK[conv_chan];
  assign is_remote = conv_chan == hwm_pkg::CH_REMOTE1 || conv_chan == hwm_pkg::CH_REMOTE2;
  assign rsel = conv_chan == hwm_pkg::CH_REMOTE2;
  assign diode_on = rsel ? temp_en[3] : temp_en[1];
  assign rfault = is_remote && diode_fault[rsel];

  always_comb
  begin
    new_val = conv_data;
    if (rfault && !diode_on)
      new_val = hwm_pkg::DISABLED_READ;
    else if (rfault && !diode_neg_gnd[rsel])
      new_val = hwm_pkg::SENSOR_ERROR;
    if (is_temp)
      err_new = $signed(new_val) <= $signed(lim_lo[conv_chan]) || $signed(new_val) >= $signed(lim_hi[conv_chan]);
    else
      err_new = new_val <= lim_lo[conv_chan] || new_val >= lim_hi[conv_chan];
    unique case (conv_chan)
      hwm_pkg::CH_REMOTE1: ind_en = temp_en[1];
      hwm_pkg::CH_AMBIENT: ind_en = temp_en[2];
      hwm_pkg::CH_REMOTE2: ind_en = temp_en[3];
      default: ind_en = volt_group_enable[conv_chan - 3'h1];
    endcase
    set1 = (upd && err_new && ind_en) ? (8'h01 << conv_chan) : 8'h00;
  end

  always_ff @(posedge mclk)
  begin
    if (upd)
      reading[conv_chan] <= new_val;
  end

  always_ff @(posedge mclk)
  begin
    if (reset || soft_init)
      cur_err <= 8'h00;
    else if (upd)
      cur_err[conv_chan] <= err_new;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status registers
  logic [7:0] st1;
  logic [7:0] st2;
  logic [7:0] set2;
  logic [7:0] st2_cond;
  logic rd_ok;

  assign rd_ok = reg_rd && !shutdown;
  assign st2_cond = {diode_fault[1], diode_fault[0], 2'b00, fan_fault};
  assign set2 = active ? (st2_cond & {temp_en[3], temp_en[1], 2'b00, fan_en[4:1]}) : 8'h00;

  // set wins over the read clear; writes to their addresses are ignored
  always_ff @(posedge mclk)
  begin
    if (reset || soft_init)
    begin
      st1 <= 8'h00;
      st2 <= 8'h00;
    end
    else
    begin
      if (rd_ok && reg_addr == hwm_pkg::ADDR_STAT1)
        st1 <= (st1 & cur_err) | set1;
      else
        st1 <= st1 | set1;
      if (rd_ok && reg_addr == hwm_pkg::ADDR_STAT2)
        st2 <= (st2 & st2_cond) | set2;
      else
        st2 <= st2 | set2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      reg_rdata <= 8'h00;
      if (rd_ok)
      begin
        unique case (reg_addr)
          hwm_pkg::ADDR_RLR: reg_rdata <= {5'h00, ready, lock, run};
          hwm_pkg::ADDR_STAT1: reg_rdata <= st1;
          hwm_pkg::ADDR_STAT2: reg_rdata <= st2;
          hwm_pkg::ADDR_SFR: reg_rdata <= sfr;
          hwm_pkg::ADDR_VOLT_GROUP_ENABLE: reg_rdata <= volt_group_enable;
          hwm_pkg::ADDR_CONFIG_REGISTER: reg_rdata <= config_register;
          hwm_pkg::ADDR_FAN_EN: reg_rdata <= fan_en;
          hwm_pkg::ADDR_TEMP_EN: reg_rdata <= temp_en;
          default:
          begin
            for (int i = 0; i < hwm_pkg::NUM_CH; i++)
            begin
              if (reg_addr == hwm_pkg::ADDR_READ_BASE + 8'(i))
                reg_rdata <= reading[i];
              if (reg_addr == hwm_pkg::ADDR_LO_BASE + 8'(i))
                reg_rdata <= lim_lo[i];
              if (reg_addr == hwm_pkg::ADDR_HI_BASE + 8'(i))
                reg_rdata <= lim_hi[i];
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert generation and routing
  logic alert_cond;
  logic released;

  // diode fault bits are left out on purpose; they act through the 80h reading
  assign alert_cond = sfr[hwm_pkg::SFR_GLOBAL_EN] && active && (
    (temp_en[hwm_pkg::GROUP_EN] && |(st1 & hwm_pkg::TEMP_CH_MASK)) ||
    (volt_group_enable[hwm_pkg::GROUP_EN] && |(st1 & hwm_pkg::VOLT_CH_MASK)) ||
    (fan_en[hwm_pkg::GROUP_EN] && |st2[3:0]));

  // a release lasts until some status bit newly sets
  always_ff @(posedge mclk)
  begin
    if (reset || soft_init)
      released <= 1'b0;
    else if (|(set1 & ~st1) || |(set2 & ~st2))
      released <= 1'b0;
    else if (ara_req && !alert_n)
      released <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      alert_n <= 1'b1;
      drive2_alert_oe <= 1'b0;
      speed3_alert_oe <= 1'b0;
    end
    else
    begin
      alert_n <= !(alert_cond && !released);
      drive2_alert_oe <= config_register[hwm_pkg::CONFIG_REGISTER_DRIVE2_ALERT] && alert_cond && !released;
      speed3_alert_oe <= config_register[hwm_pkg::CONFIG_REGISTER_SPEED3_ALERT] && alert_cond && !released;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fan forcing and power control
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      zone_full_on <= 3'b111;
      osc_enable <= 1'b1;
      adc_enable <= 1'b0;
    end
    else
    begin
      zone_full_on[0] <= !run || reading[hwm_pkg::CH_REMOTE1] == hwm_pkg::SENSOR_ERROR;
      zone_full_on[1] <= !run || reading[hwm_pkg::CH_AMBIENT] == hwm_pkg::SENSOR_ERROR;
      zone_full_on[2] <= !run || reading[hwm_pkg::CH_REMOTE2] == hwm_pkg::SENSOR_ERROR;
      osc_enable <= !shutdown;
      adc_enable <= run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_stat_keep;
    !(rd_ok && reg_addr == hwm_pkg::ADDR_STAT1) && !soft_init |=> (st1 & $past(st1)) == $past(st1);
  endproperty
  a_stat_keep: assert property (p_stat_keep) else $error("status bit fell without a read");

  property p_read_clear;
    rd_ok && reg_addr == hwm_pkg::ADDR_STAT1 && !soft_init && set1 == 8'h00 |=> st1 == $past(st1 & cur_err);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read clear wrong");

  property p_limit_set;
    upd && err_new && ind_en && !soft_init |=> st1[$past(conv_chan)];
  endproperty
  a_limit_set: assert property (p_limit_set) else $error("limit hit did not set status");

  property p_lock;
    lock && reg_wr && reg_addr == hwm_pkg::ADDR_RLR && !soft_init |=> run == $past(run);
  endproperty
  a_lock: assert property (p_lock) else $error("run changed while locked");

  property p_low_power_quiet;
    !run |=> alert_n && !drive2_alert_oe && zone_full_on == 3'b111;
  endproperty
  a_low_power_quiet: assert property (p_low_power_quiet) else $error("alert or fan drive in low power");

  property p_fault80;
    upd && is_remote && diode_fault[rsel] && diode_on && !diode_neg_gnd[rsel]
      |=> reading[$past(conv_chan)] == hwm_pkg::SENSOR_ERROR;
  endproperty
  a_fault80: assert property (p_fault80) else $error("faulty diode not forced to 80h");

  property p_disabled00;
    upd && is_remote && diode_fault[rsel] && !diode_on |=> reading[$past(conv_chan)] == hwm_pkg::DISABLED_READ;
  endproperty
  a_disabled00: assert property (p_disabled00) else $error("disabled diode not loaded with 00h");

  property p_alert_on;
    alert_cond && !released ##1 alert_cond |-> !alert_n;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("alert not asserted");

  property p_ara;
    ara_req && !alert_n && set1 == 8'h00 && set2 == 8'h00 && !soft_init |=> ##1 alert_n;
  endproperty
  a_ara: assert property (p_ara) else $error("alert response did not release");

  property p_status_ro;
    reg_wr && (reg_addr == hwm_pkg::ADDR_STAT1) && !reg_rd && set1 == 8'h00 && !soft_init |=> $stable(st1);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status register took a write");

  property p_sleep_stop;
    !run |=> !conv_start [*2];
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("conversion in low power");

  property p_pause;
    pass_done && !soft_init |=> state == hwm_pkg::HWM_PAUSE && !conv_start;
  endproperty
  a_pause: assert property (p_pause) else $error("no idle after pass");

  c_pass: cover property (pass_done);
  c_alert: cover property (alert_n ##1 !alert_n);
  c_ara: cover property (ara_req && !alert_n ##2 alert_n);
  c_shutdown: cover property (run ##1 shutdown);

endmodule // hwm_irq_pwr

// ==== test/hwm_conv_model.sv ====
// Purpose: behavioural converter answering the monitor's conversion requests
// Assumes: one request outstanding at a time, values per channel from the bench
// Notes: latency grows with channel number so prompt and slow answers both occur
`timescale 1ns/10ps
module hwm_conv_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire logic [63:0] chan_vals,
  output logic conv_done,
  output logic [7:0] conv_data
);
  logic busy;
  logic [3:0] wait_cnt;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 8'h00;
    end
    else if (conv_start)
    begin
      busy <= 1'b1;
      wait_cnt <= {1'b0, conv_chan};
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end
    else if (busy && wait_cnt == 4'h0)
    begin
      busy <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= chan_vals[{conv_chan, 3'b000} +: 8];
    end
    else
    begin
      // data is only good with the done pulse, so it toggles otherwise
      wait_cnt <= wait_cnt - 4'h1;
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end
  end
endmodule // hwm_conv_model

// ==== test/tb_hwm_irq_pwr.sv ====
// Purpose: self-checking bench for the monitor event and power block
// Assumes: converter model on the far side, idle wait shortened to 20 cycles
// Notes: fan fault pins held inactive except pin 0, driven high for a while in t_fan
`timescale 1ns/10ps
module tb_hwm_irq_pwr;
  logic mclk, reset, reg_wr, reg_rd, ara_req, conv_start, conv_done, reg_rvalid, alert_n;
  logic drive2_alert_oe, speed3_alert_oe, osc_enable, adc_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_data;
  logic [2:0] conv_chan, zone_full_on, next_chan;
  logic [1:0] diode_fault_pin, diode_neg_gnd_pin;
  logic [3:0] fan_fault_pin;
  logic [63:0] chan_vals;
  int n_fail, checked;

  hwm_irq_pwr #(.IDLE_CYCLES(20)) hwm_irq_pwr_i (.mclk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .ara_req, .conv_start, .conv_chan, .conv_done, .conv_data, .diode_fault_pin,
    .diode_neg_gnd_pin, .fan_fault_pin, .alert_n, .drive2_alert_oe, .speed3_alert_oe, .zone_full_on,
    .osc_enable, .adc_enable);
  hwm_conv_model hwm_conv_model_i (.mclk, .reset, .conv_start, .conv_chan, .chan_vals, .conv_done, .conv_data);
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pin(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    pin("rvalid", reg_rvalid, 1'b1);
    check(what, reg_rdata, exp);
  endtask
  // a whole pass from channel 0 so data changed beforehand is seen everywhere
  task automatic wait_pass();
    int i;
    i = 0;
    while (!(conv_start === 1'b1 && conv_chan === 3'h0) && i < 10000)
    begin
      cyc(1);
      i++;
    end
    while (!(conv_done === 1'b1 && conv_chan === 3'h7) && i < 10000)
    begin
      cyc(1);
      i++;
    end
    if (i >= 10000)
    begin
      n_fail++;
      complete_run();
    end
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    #1;
    if (adc_enable !== 1'b1)
      next_chan = 3'h0;
    else if (conv_start === 1'b1)
    begin
      check("chan order", {5'h00, conv_chan}, {5'h00, next_chan});
      next_chan = next_chan + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h41, 8'h00, "st1 reset");
    wr(8'h41, 8'hff);
    rd(8'h41, 8'h00, "st1 write");
    wr(8'h42, 8'hff);
    rd(8'h42, 8'h00, "st2 write");
    rd(8'h7c, 8'h40, "sfr reset");
    rd(8'h99, 8'h00, "unmapped");
    check("zone stopped", {5'h00, zone_full_on}, 8'h07);
  endtask
  task automatic t_volt();
    wr(8'h46, 8'h10);
    wr(8'h4e, 8'h50);
    wr(8'h47, 8'h10);
    wr(8'h7e, 8'h07);
    wr(8'h7f, 8'h02);
    wr(8'h7c, 8'h44);
    wr(8'h40, 8'h01);
    wait_pass();
    rd(8'h22, 8'h50, "vcc reading");
    pin("alert volt", alert_n, 1'b0);
    pin("drive2 oe", drive2_alert_oe, 1'b1);
    pin("speed3 oe", speed3_alert_oe, 1'b0);
    // channel 0 sits at its high limit but its enable is clear
    rd(8'h41, 8'h0c, "st1 volt");
    rd(8'h41, 8'h0c, "st1 persist");
    @(posedge mclk);
    ara_req <= 1'b1;
    @(posedge mclk);
    ara_req <= 1'b0;
    cyc(3);
    pin("alert ara", alert_n, 1'b1);
  endtask
  task automatic t_clear();
    chan_vals <= 64'h00404040_2030207f;
    wait_pass();
    rd(8'h41, 8'h0c, "st1 sticky");
    rd(8'h41, 8'h00, "st1 cleared");
  endtask
  task automatic t_diode();
    @(posedge mclk);
    diode_fault_pin <= 2'b11;
    wr(8'h82, 8'h03);
    wait_pass();
    rd(8'h20, 8'h80, "remote1 fault");
    rd(8'h27, 8'h00, "remote2 off");
    rd(8'h42, 8'h40, "st2 fault");
    check("zone fault", {5'h00, zone_full_on}, 8'h01);
    pin("alert temp", alert_n, 1'b0);
    rd(8'h41, 8'h01, "st1 temp");
    @(posedge mclk);
    diode_neg_gnd_pin <= 2'b01;
    chan_vals[7:0] <= 8'h25;
    wait_pass();
    rd(8'h20, 8'h25, "remote1 gnd");
  endtask
  // temperature group off so only the fan error can hold the alert
  task automatic t_fan();
    wr(8'h82, 8'h02);
    wr(8'h80, 8'h03);
    wr(8'h7f, 8'h03);
    @(posedge mclk);
    fan_fault_pin <= 4'h1;
    cyc(5);
    pin("alert fan", alert_n, 1'b0);
    pin("speed3 fan", speed3_alert_oe, 1'b1);
    rd(8'h42, 8'h41, "st2 fan");
    @(posedge mclk);
    fan_fault_pin <= 4'h0;
    cyc(3);
    rd(8'h42, 8'h41, "st2 fan sticky");
    rd(8'h42, 8'h40, "st2 fan cleared");
    pin("alert fan off", alert_n, 1'b1);
  endtask
  task automatic t_power();
    @(posedge mclk);
    diode_fault_pin <= 2'b00;
    diode_neg_gnd_pin <= 2'b00;
    wr(8'h40, 8'h00);
    cyc(2);
    pin("adc sleep", adc_enable, 1'b0);
    pin("osc sleep", osc_enable, 1'b1);
    pin("alert sleep", alert_n, 1'b1);
    check("zone sleep", {5'h00, zone_full_on}, 8'h07);
    wr(8'h7c, 8'h45);
    cyc(2);
    pin("osc off", osc_enable, 1'b0);
    rd(8'h7e, 8'h00, "shutdown read");
    wr(8'h7f, 8'h01);
    wr(8'h7c, 8'h44);
    cyc(2);
    pin("osc back", osc_enable, 1'b1);
    rd(8'h7f, 8'h01, "config in shutdown");
    rd(8'h7e, 8'h07, "volt_group_enable kept");
    wr(8'h40, 8'h02);
    wr(8'h40, 8'h03);
    wr(8'h7c, 8'h45);
    cyc(2);
    pin("run locked", adc_enable, 1'b0);
    pin("lpsel locked", osc_enable, 1'b1);
    wr(8'h7f, 8'h80);
    rd(8'h7f, 8'h00, "init self clear");
    rd(8'h7e, 8'h00, "init volt_group_enable");
    rd(8'h20, 8'h25, "init reading");
    wr(8'h40, 8'h01);
    cyc(2);
    pin("run unlocked", adc_enable, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ara_req = 1'b0;
    diode_fault_pin = 2'b00;
    diode_neg_gnd_pin = 2'b00;
    fan_fault_pin = 4'h0;
    chan_vals = 64'h00404040_1050207f;
    n_fail = 0;
    checked = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_volt();
    t_clear();
    t_diode();
    t_fan();
    t_power();
    complete_run();
  end
endmodule // tb_hwm_irq_pwr
